// >>> inc/eeprom_pkg.sv
package eeprom_pkg;
  // ==========================================================================
  // Array geometry
  localparam int          ADDR_W        = 8;
  localparam int          DEPTH         = 256;
  localparam logic [7:0]  PROT_BASE     = 8'h80;  // Upper half is read-only
  localparam logic [7:0]  ID48_FIRST    = 8'hFA;
  localparam logic [7:0]  ID64_FIRST    = 8'hF8;
  localparam logic [7:0]  ID_LAST       = 8'hFF;
  localparam logic [15:0] ID_RSV_A      = 16'hFFFE;
  localparam logic [15:0] ID_RSV_B      = 16'hFFFF;
  // ==========================================================================
  // Control byte fields
  localparam logic [3:0]  TYPE_CODE     = 4'b1010;
  localparam int          TYPE_MSB      = 7;
  localparam int          CS_MSB        = 3;
  localparam int          CS_LSB        = 1;
  localparam int          RW_BIT        = 0;
  // ==========================================================================
  // Timing
  localparam int          CLK_MHZ       = 40;
  localparam int          GLITCH_NS     = 50;
  localparam int          GLITCH_CYC    = (GLITCH_NS * CLK_MHZ) / 1000 < 1 ? 1 : (GLITCH_NS * CLK_MHZ) / 1000;
  localparam int          WRITE_US      = 3000;
  localparam int          WRITE_CYC     = WRITE_US * CLK_MHZ;
  // ==========================================================================
  // Carriers
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [7:0]        data;
  } wr_req_t;
endpackage

// >>> src/eeprom_mem.sv
`timescale 1ns/100ps
// ============================================================================
// Byte array with registered read data and a factory identity image
module eeprom_mem
  import eeprom_pkg::*;
#(
  parameter bit          ID_IS_64 = 1'b0,
  parameter logic [63:0] ID_VALUE = 64'h0000_0000_0000_0000  // Arbitrary identity
) (
  input  wire logic              clk_sys,
  input  wire logic              we,
  input  wire wr_req_t           wr,
  input  wire logic [ADDR_W-1:0] raddr,
  output logic [7:0]             rdata
);
  logic [7:0] mem [DEPTH];
  logic [7:0] id_byte;
  logic       id_hit;

  // Identity overlays the top bytes; the array itself never holds it
  always_comb begin
    id_hit  = ID_IS_64 ? (raddr >= ID64_FIRST) : (raddr >= ID48_FIRST);
    id_byte = ID_VALUE[8*(7 - (raddr - ID64_FIRST)) +: 8];
    if (!ID_IS_64) begin
      id_byte = ID_VALUE[8*(5 - (raddr - ID48_FIRST)) +: 8];
    end
  end

  // Write port
  always_ff @(posedge clk_sys) begin
    if (we) begin
      mem[wr.addr] <= wr.data;
    end
  end

  // Registered read port
  always_ff @(posedge clk_sys) begin
    rdata <= id_hit ? id_byte : mem[raddr];
  end

  // Reserved extension prefixes are never stored
  id_rsv_a : assert property (@(posedge clk_sys) ID_IS_64 |-> (ID_VALUE[39:24] != ID_RSV_A && ID_VALUE[39:24] != ID_RSV_B))
    else $error("Identity uses a reserved extension prefix");
endmodule

// >>> src/eeprom_node.sv
`timescale 1ns/100ps
// Behaviour
// - No acknowledge to control bytes while the internal write cycle runs.
// - Read uses control byte with direction bit set; three read kinds supported.
// - Address counter holds last accessed location plus one.
// - Read control byte acknowledged, then one byte shifted out until not acknowledged.
// - Random read loads the pointer from the word address without writing.
// - Controller acknowledge after a read byte sends the next byte.
// - Pointer increments by one after every byte operation.
// - Low supply blocks all erase and program activity.
// - Clock and data inputs are glitch filtered.
// - Upper half cannot be written; its top bytes hold a fixed identity.
// - 48-bit identity sits in six top bytes.
// - 64-bit identity sits in eight top bytes.
// - 64-bit extension never starts with the two reserved values.
// - Respond only to control bytes carrying the device-type code.
// - Writes to the upper range are ignored; reads proceed.
// - After no acknowledge the data line is released high.
// - Chip-select bits must match the select pins when enabled.
module eeprom_node
  import eeprom_pkg::*;
#(
  parameter bit          ID_IS_64   = 1'b0,
  parameter bit          HAS_CS     = 1'b0,
  parameter int          WRITE_CNT  = WRITE_CYC,
  parameter logic [63:0] ID_VALUE   = 64'h0000_0000_0000_0000  // Arbitrary identity
) (
  input  wire logic clk_sys,
  input  wire logic rst_n,
  input  wire logic scl_in,
  input  wire logic sda_in,
  output logic      sda_out,
  output logic      sda_oe,
  input  wire logic chip_select_bit2,
  input  wire logic chip_select_bit1,
  input  wire logic chip_select_bit0,
  input  wire logic supply_low,
  output logic      write_busy
);
  typedef enum logic [2:0] {S_IDLE, S_CTRL, S_WADDR, S_WDATA, S_READ, S_RACK, S_IGNORE} state_t;

  state_t            state_q;
  logic [3:0]        bit_q;
  logic [7:0]        shift_q;
  logic [ADDR_W-1:0] ptr_q;
  logic              ack_q;
  logic              scl_f_q, sda_f_q, scl_p_q, sda_p_q;
  logic [7:0]        scl_cnt_q, sda_cnt_q;
  logic [7:0]        rdata;
  logic              wr_seen_q;
  logic              start_ev, stop_ev, rise_ev, fall_ev;
  logic              cs_ok, ctl_ok;
  logic [31:0]       wt_cnt_q;
  // Two-entry buffer of pending writes
  wr_req_t           buf_q [2];
  logic [1:0]        buf_n_q;
  logic              buf_in_v, buf_in_r, buf_out_v, buf_out_r;
  logic              mem_we;

  // ==========================================================================
  // Input filtering
  // A level must persist GLITCH_CYC cycles before it is accepted, so spikes vanish
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      scl_f_q   <= 1'b1;
      sda_f_q   <= 1'b1;
      scl_cnt_q <= 8'h00;
      sda_cnt_q <= 8'h00;
    end else begin
      scl_cnt_q <= (scl_in == scl_f_q) ? 8'h00 : scl_cnt_q + 8'h01;
      sda_cnt_q <= (sda_in == sda_f_q) ? 8'h00 : sda_cnt_q + 8'h01;
      if (scl_in != scl_f_q && scl_cnt_q >= 8'(GLITCH_CYC - 1)) begin
        scl_f_q   <= scl_in;
        scl_cnt_q <= 8'h00;
      end
      if (sda_in != sda_f_q && sda_cnt_q >= 8'(GLITCH_CYC - 1)) begin
        sda_f_q   <= sda_in;
        sda_cnt_q <= 8'h00;
      end
    end
  end

  // Previous filtered levels for edge and condition detection
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      scl_p_q <= scl_f_q;
      sda_p_q <= sda_f_q;
    end
  end

  assign start_ev = scl_f_q && scl_p_q && sda_p_q && !sda_f_q;
  assign stop_ev  = scl_f_q && scl_p_q && !sda_p_q && sda_f_q;
  assign rise_ev  = scl_f_q && !scl_p_q;
  assign fall_ev  = !scl_f_q && scl_p_q;

  // ==========================================================================
  // Control byte decode
  always_comb begin
    cs_ok  = !HAS_CS || (shift_q[CS_MSB:CS_LSB] == {chip_select_bit2, chip_select_bit1, chip_select_bit0});
    ctl_ok = (shift_q[TYPE_MSB -: 4] == TYPE_CODE) && cs_ok && !write_busy;
  end

  // ==========================================================================
  // Bus protocol
  // Received bits counted on rising clock, sent bits on falling clock; ninth clock is the acknowledge slot
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= S_IDLE;
      bit_q   <= 4'h0;
      shift_q <= 8'h00;
      ack_q   <= 1'b0;
    end else if (start_ev) begin
      state_q <= S_CTRL;  // Repeated start also ends a write phase: pointer kept
      bit_q   <= 4'h0;
      ack_q   <= 1'b0;
    end else if (stop_ev) begin
      state_q <= S_IDLE;
      ack_q   <= 1'b0;
    end else begin
      case (state_q)
        S_CTRL, S_WADDR, S_WDATA: begin
          if (rise_ev && bit_q < 4'd8) begin
            shift_q <= {shift_q[6:0], sda_f_q};
            bit_q   <= bit_q + 4'h1;
          end
          if (fall_ev && bit_q == 4'd8) begin
            // Drive acknowledge through the ninth clock
            ack_q <= (state_q != S_CTRL) || ctl_ok;
            bit_q <= 4'd9;
            if (state_q == S_CTRL && !ctl_ok) begin
              state_q <= S_IGNORE;
            end
          end
          if (fall_ev && bit_q == 4'd9) begin
            ack_q <= 1'b0;
            bit_q <= 4'h0;
            if (state_q == S_CTRL) begin
              state_q <= shift_q[RW_BIT] ? S_READ : S_WADDR;
            end else if (state_q == S_WADDR) begin
              state_q <= S_WDATA;
            end
          end
        end
        S_READ: begin
          if (fall_ev) begin
            bit_q <= bit_q + 4'h1;
            if (bit_q == 4'd7) begin
              state_q <= S_RACK;
              bit_q   <= 4'h0;
            end
          end
        end
        S_RACK: begin
          // Controller acknowledge keeps the stream going
          // Decide on the rise, but start the next byte only after the fall so its first bit is not lost
          if (rise_ev) begin
            if (sda_f_q) begin
              state_q <= S_IGNORE;
            end else begin
              bit_q <= 4'h1;  // Acknowledge seen, wait for the clock to fall
            end
          end
          if (fall_ev && bit_q == 4'h1) begin
            state_q <= S_READ;
            bit_q   <= 4'h0;
          end
        end
        S_IDLE, S_IGNORE: begin
          bit_q <= 4'h0;
        end
        default: state_q <= S_IDLE;
      endcase
    end
  end

  // ==========================================================================
  // Address pointer
  // Advances after every data byte in both directions and wraps by width
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ptr_q <= '0;
    end else if (!start_ev && !stop_ev) begin
      if (state_q == S_WADDR && fall_ev && bit_q == 4'd8) begin
        ptr_q <= shift_q;
      end else if (state_q == S_WDATA && fall_ev && bit_q == 4'd8) begin
        ptr_q <= ptr_q + 1'b1;
      end else if (state_q == S_RACK && rise_ev) begin
        ptr_q <= ptr_q + 1'b1;
      end
    end
  end

  // ==========================================================================
  // Write queue
  // Received bytes below PROT_BASE queue here; the array port may refuse while supply is low
  assign buf_in_v  = state_q == S_WDATA && fall_ev && bit_q == 4'd8 && !start_ev && !stop_ev
                     && ptr_q < PROT_BASE;
  assign buf_in_r  = buf_n_q != 2'd2;
  assign buf_out_v = buf_n_q != 2'd0;
  assign buf_out_r = !supply_low;
  assign mem_we    = buf_out_v && buf_out_r;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      buf_n_q  <= 2'd0;
      buf_q[0] <= '0;
      buf_q[1] <= '0;
    end else begin
      if (mem_we) begin
        buf_q[0] <= buf_q[1];
      end
      if (buf_in_v && buf_in_r) begin
        buf_q[(mem_we ? buf_n_q - 2'd1 : buf_n_q) == 2'd0 ? 0 : 1] <= '{addr: ptr_q, data: shift_q};
      end
      buf_n_q <= buf_n_q + 2'(buf_in_v && buf_in_r) - 2'(mem_we);
    end
  end

  // Remembers that this transaction queued a byte; the queue may already be drained at Stop
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wr_seen_q <= 1'b0;
    end else if (buf_in_v && buf_in_r) begin
      wr_seen_q <= 1'b1;
    end else if (start_ev || stop_ev) begin
      wr_seen_q <= 1'b0;
    end
  end

  // Self-timed write cycle begins at Stop after data was taken
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wt_cnt_q <= '0;
    end else if (stop_ev && state_q == S_WDATA && wr_seen_q) begin
      wt_cnt_q <= 32'(WRITE_CNT);
    end else if (wt_cnt_q != 0 && !supply_low) begin
      wt_cnt_q <= wt_cnt_q - 32'd1;
    end
  end
  assign write_busy = wt_cnt_q != 0;

  eeprom_mem #(
    .ID_IS_64 (ID_IS_64),
    .ID_VALUE (ID_VALUE)
  ) u_mem (
    .clk_sys (clk_sys),
    .we      (mem_we),
    .wr      (buf_q[0]),
    .raddr   (ptr_q),
    .rdata   (rdata)
  );

  // ==========================================================================
  // Data line drive; only ever pulls low, released means high
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sda_oe <= 1'b0;
    end else begin
      sda_oe <= ack_q || (state_q == S_READ && !rdata[3'd7 - bit_q[2:0]]);
    end
  end
  assign sda_out = 1'b0;

  // ==========================================================================
  // Checks
  busy_no_ack_a : assert property (@(posedge clk_sys) disable iff (!rst_n)
    (state_q == S_CTRL && fall_ev && bit_q == 4'd8 && write_busy && !start_ev && !stop_ev) |=> !ack_q)
    else $error("Acknowledged during write cycle");
  prot_write_a : assert property (@(posedge clk_sys) disable iff (!rst_n)
    buf_in_v |-> ptr_q < PROT_BASE)
    else $error("Write queued to protected range");
  low_supply_a : assert property (@(posedge clk_sys) disable iff (!rst_n)
    supply_low |-> !mem_we)
    else $error("Array written under low supply");
  ptr_step_a : assert property (@(posedge clk_sys) disable iff (!rst_n)
    (state_q == S_RACK && rise_ev && !start_ev && !stop_ev) |=> ptr_q == $past(ptr_q) + 8'h01)
    else $error("Pointer did not advance");
  nack_release_a : assert property (@(posedge clk_sys) disable iff (!rst_n)
    (state_q == S_IGNORE) |=> !sda_oe)
    else $error("Data line held after no acknowledge");
  bad_type_a : assert property (@(posedge clk_sys) disable iff (!rst_n)
    (state_q == S_CTRL && fall_ev && bit_q == 4'd8 && shift_q[7:4] != TYPE_CODE && !start_ev && !stop_ev)
    |=> state_q == S_IGNORE)
    else $error("Foreign control byte accepted");
  cs_mismatch_a : assert property (@(posedge clk_sys) disable iff (!rst_n)
    (state_q == S_CTRL && fall_ev && bit_q == 4'd8 && HAS_CS && !start_ev && !stop_ev
     && shift_q[CS_MSB:CS_LSB] != {chip_select_bit2, chip_select_bit1, chip_select_bit0}) |=> state_q == S_IGNORE)
    else $error("Control byte for another select address accepted");
  write_start_a : assert property (@(posedge clk_sys) disable iff (!rst_n)
    (stop_ev && state_q == S_WDATA && wr_seen_q) |=> write_busy)
    else $error("Write cycle did not start at Stop");
  ptr_wrap_a : assert property (@(posedge clk_sys) disable iff (!rst_n)
    (state_q == S_RACK && rise_ev && ptr_q == ID_LAST && !start_ev && !stop_ev) |=> ptr_q == '0)
    else $error("Pointer did not wrap to zero");
  // Filter is two cycles deep: a new level must have stood on the pin for both previous samples
  scl_filter_a : assert property (@(posedge clk_sys) disable iff (!rst_n)
    $changed(scl_f_q) |-> ($past(scl_in) == scl_f_q && $past(scl_in, 2) == scl_f_q))
    else $error("Clock filter passed a short pulse");
endmodule

// >>> verification/bus_ctrl.sv
`timescale 1ns/100ps
// ============================================================================
// Bus controller model: owns the clock line, lets data go to the pull-up
module bus_ctrl #(
  parameter int Q = 8  // System cycles per quarter bit
) (
  input  wire logic clk_sys,
  output logic      scl,
  output logic      sda_drv,
  input  wire logic sda
);
  logic glitch;  // Adds a one-cycle clock spike, shorter than the filter

  // Idle bus: both lines high
  initial begin
    scl     = 1'b1;
    sda_drv = 1'b1;
    glitch  = 1'b0;
  end

  task automatic wq();
    repeat (Q) @(negedge clk_sys);
  endtask

  // Data changes only while the clock is low; sampled mid-high
  task automatic bit_io(input logic o, output logic i);
    scl = 1'b0;
    wq();
    sda_drv = o;
    if (glitch) begin
      scl = 1'b1;
      @(negedge clk_sys);
      scl = 1'b0;
    end
    wq();
    scl = 1'b1;
    wq();
    i = sda;
    wq();
  endtask

  // Start, also repeated Start after a byte
  task automatic start();
    scl = 1'b0;
    wq();
    sda_drv = 1'b1;
    wq();
    scl = 1'b1;
    wq();
    sda_drv = 1'b0;
    wq();
  endtask

  task automatic stop();
    scl = 1'b0;
    wq();
    sda_drv = 1'b0;
    wq();
    scl = 1'b1;
    wq();
    sda_drv = 1'b1;
    wq();
  endtask

  // Eight bits MSB first, then the target's acknowledge slot
  task automatic put_byte(input logic [7:0] b, output logic ack);
    logic a;
    for (int k = 7; k >= 0; k--) begin
      bit_io(b[k], a);
    end
    bit_io(1'b1, a);
    ack = ~a;
  endtask

  // Read one byte; acknowledge asks for more, no acknowledge ends the read
  task automatic get_byte(input logic ack, output logic [7:0] b);
    logic a;
    for (int k = 7; k >= 0; k--) begin
      bit_io(1'b1, b[k]);
    end
    bit_io(~ack, a);
  endtask
endmodule

// >>> verification/testbench.sv
`timescale 1ns/100ps
module testbench;
  import eeprom_pkg::*;
  localparam logic [63:0] ID = 64'h0000_1122_3344_5566;  // Arbitrary identity
  logic clk_sys;
  logic rst_n;
  logic supply_low;
  logic sda_out;
  logic sda_oe;
  logic write_busy;
  logic [2:0] cs_pins;  // Select pin levels
  logic scl;
  logic sda_drv;
  wire  sda = (sda_oe ? sda_out : 1'b1) & sda_drv;  // Pull-up wire
  int   n_fail;
  int   checks;
  int   cycles;

  eeprom_node #(.ID_IS_64(1'b0), .HAS_CS(1'b1), .WRITE_CNT(1000), .ID_VALUE(ID)) i_dut (
    .clk_sys(clk_sys), .rst_n(rst_n), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe(sda_oe), .chip_select_bit2(cs_pins[2]), .chip_select_bit1(cs_pins[1]), .chip_select_bit0(cs_pins[0]),
    .supply_low(supply_low), .write_busy(write_busy));
  bus_ctrl #(.Q(8)) i_ctrl (.clk_sys(clk_sys), .scl(scl), .sda_drv(sda_drv), .sda(sda));

  // ==========================================================================
  // Checking and closing
  task automatic cmp_bit(input string nm, input logic e, input logic g);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("BAD %s expected %b seen %b", nm, e, g);
    end
  endtask

  task automatic cmp_byte(input string nm, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // ==========================================================================
  // Bus sequences
  // Two-byte write, then polls; a busy target must refuse the first poll
  task automatic do_write(input logic [7:0] a, input logic [7:0] d0, input logic [7:0] d1, input bit busy);
    logic ack;
    int   n;
    i_ctrl.start();
    i_ctrl.put_byte(8'hA0, ack);
    cmp_bit("write ctl ack", 1'b1, ack);
    i_ctrl.put_byte(a, ack);
    i_ctrl.put_byte(d0, ack);
    i_ctrl.put_byte(d1, ack);
    i_ctrl.stop();
    if (busy) begin
      cmp_bit("write_busy", 1'b1, write_busy);
      i_ctrl.start();
      i_ctrl.put_byte(8'hA0, ack);
      cmp_bit("busy poll ack", 1'b0, ack);
      i_ctrl.stop();
    end
    ack = 1'b0;
    n = 0;
    while (!ack && n < 20) begin
      i_ctrl.start();
      i_ctrl.put_byte(8'hA0, ack);
      i_ctrl.stop();
      n++;
    end
    cmp_bit("poll ack", 1'b1, ack);
  endtask

  // Optional pointer load, then read; the last byte is not acknowledged
  task automatic read_bytes(input bit set, input logic [7:0] a, input logic [7:0] exp[$]);
    logic       ack;
    logic [7:0] d;
    if (set) begin
      i_ctrl.start();
      i_ctrl.put_byte(8'hA0, ack);
      i_ctrl.put_byte(a, ack);
    end
    i_ctrl.start();
    i_ctrl.put_byte(8'hA1, ack);
    cmp_bit("read ctl ack", 1'b1, ack);
    foreach (exp[k]) begin
      i_ctrl.get_byte(k < exp.size() - 1, d);
      cmp_byte("read data", exp[k], d);
    end
    cmp_bit("sda released", 1'b1, sda);
    i_ctrl.stop();
  endtask

  // ==========================================================================
  // Scenarios
  task automatic t_write_read();
    do_write(8'h00, 8'h5A, 8'h3C, 1'b1);
    read_bytes(1'b1, 8'h00, '{8'h5A});
    i_ctrl.glitch = 1'b1;
    read_bytes(1'b0, 8'h00, '{8'h3C});
    i_ctrl.glitch = 1'b0;
  endtask

  // Identity bytes, then wrap past the top location to zero
  task automatic t_seq_wrap();
    // These six bytes are what an application encapsulates into the 64-bit form
    read_bytes(1'b1, 8'hFA, '{ID[47:40], ID[39:32], ID[31:24], ID[23:16], ID[15:8], ID[7:0], 8'h5A});
  endtask

  // Low supply freezes the write timer and holds queued bytes back until it recovers
  task automatic t_low_supply();
    logic ack;
    supply_low = 1'b1;
    i_ctrl.start();
    i_ctrl.put_byte(8'hA0, ack);
    i_ctrl.put_byte(8'h10, ack);
    i_ctrl.put_byte(8'hA5, ack);
    i_ctrl.put_byte(8'h77, ack);
    i_ctrl.stop();
    repeat (1200) @(negedge clk_sys);
    cmp_bit("busy under low supply", 1'b1, write_busy);
    supply_low = 1'b0;
    repeat (1100) @(negedge clk_sys);
    cmp_bit("busy after recovery", 1'b0, write_busy);
    read_bytes(1'b1, 8'h10, '{8'hA5, 8'h77});
  endtask

  task automatic t_protect();
    do_write(8'hFA, 8'h00, 8'hFF, 1'b0);
    read_bytes(1'b1, 8'hFA, '{ID[47:40], ID[39:32]});
  endtask

  task automatic t_bad_type();
    logic ack;
    i_ctrl.start();
    i_ctrl.put_byte(8'hB0, ack);
    cmp_bit("foreign type ack", 1'b0, ack);
    i_ctrl.stop();
    i_ctrl.start();
    i_ctrl.put_byte(8'hA2, ack);
    cmp_bit("select mismatch ack", 1'b0, ack);
    i_ctrl.stop();
    cs_pins = 3'b001;
    i_ctrl.start();
    i_ctrl.put_byte(8'hA2, ack);
    cmp_bit("select match ack", 1'b1, ack);
    i_ctrl.stop();
    cs_pins = 3'b000;
  endtask

  // ==========================================================================
  // Clock, run limit and main sequence
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  // About 16700 cycles are expected; the ceiling leaves ample margin
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 60000) begin
      n_fail++;
      print_verdict();
    end
  end

  initial begin
    rst_n      = 1'b0;
    supply_low = 1'b0;
    cs_pins    = 3'b000;
    n_fail     = 0;
    checks     = 0;
    cycles     = 0;
    repeat (3) @(negedge clk_sys);
    rst_n = 1'b1;
    repeat (4) @(negedge clk_sys);
    t_write_read();
    t_seq_wrap();
    t_protect();
    t_low_supply();
    t_bad_type();
    print_verdict();
  end
endmodule
